// *** hw/dma_consts.svh ***
// register offsets, field positions and response codes of the dma controller
// assumes a 12-bit byte address on the axi4-lite slave port
`ifndef DMA_CONSTS_SVH
`define DMA_CONSTS_SVH
// ***************************************************
// register map
// ***************************************************
`define GLB_PAGE 4'h1
`define F_CFG 3'h0
`define F_ADDR 3'h1
`define F_SIZE 3'h2
`define F_NADDR 3'h3
`define F_NSIZE 3'h4
`define F_LAST 3'h4
`define G_DONE 4'h0
`define G_MASK 4'h1
`define G_BERR 4'h2
`define G_SEA 4'h3
`define G_SER 4'h4
`define G_LEA 4'h5
`define G_LER 4'h6
`define G_FIFO 4'h7
// ***************************************************
// channel config fields, error flag bits, response codes and address step
// ***************************************************
`define CB_ACTIVE 0
`define CB_BUS 1
`define CB_FLY 2
`define CB_INT 3
`define CB_FLUSH 4
`define CB_CHAIN 5
`define CB_RQ_LO 8
`define CB_RQ_HI 10
`define CFG_W 11
`define BERR_SYS 0
`define BERR_LOC 1
`define RESP_OK 2'h0
`define RESP_SLVERR 2'h2
`define ADDR_STEP 32'h4
`endif

// *** hw/dma_pkg.sv ***
// types shared by the dma controller
// assumes dma_consts.svh is not needed here
`default_nettype none
package dma_pkg;
   // engine state: no access or one access outstanding
   typedef enum logic {ENG_IDLE, ENG_ACCESS} eng_t;
   // register decode result
   typedef struct packed {
      logic ok;
      logic glb;
      logic [2:0] ch;
      logic [3:0] fld;
   } dec_t;
endpackage
`default_nettype wire

// *** hw/dual_bus_dma_controller.sv ***
// dual bus dma controller: channels, pair fifos, axi4-lite registers
// assumes both buses synchronous to clk_sys, one access at a time each
// Function
// [RL1] bus select bit picks local bus when clear, system bus when set
// [RL2] source read lands in fifo, bus released, destination bus asked later
// [RL3] chained buffer reloads next address and size when count hits zero
// [RL4] flush attribute holds new reads until the fifo drains empty
// [RL5] software should flush when chained buffers sit on different buses
// [RL6] any bus error raises non-maskable interrupt and error status
// [RL7] system error sets its flag, captures address and requestor
// [RL8] local error sets its flag, captures address and requestor
// [RL9] a new channel may start in the cycle the previous one ends
// [RL10] dual access reads into fifo and writes out, two channels
// [RL11] even channel of a pair reads, following odd channel writes
// [RL12] flyby moves data on one bus with one channel, no fifo
// [RL13] flyby uses even channel for memory reads, odd for writes
// [RL14] flyby channel uses external request, address is memory
// [RL15] requests from host port, filter, four externals, or internal
// [RL16] fifo keeps source order with no loss or reordering
`include "dma_consts.svh"
`default_nettype none
module dual_bus_dma_controller #(
   parameter int NCH = 8,
   parameter int DEPTH = 4
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // axi4-lite slave
   input wire logic [11:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [11:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   // requestors
   input wire logic host_port_req,
   input wire logic filter_coprocessor_req,
   input wire logic [3:0] ext_req,
   // shared access fields, both buses
   output logic acc_we,
   output logic acc_fly,
   output logic [31:0] acc_addr,
   output logic [31:0] acc_wdata,
   // local bus
   output logic lb_req,
   input wire logic lb_ack,
   input wire logic lb_err,
   input wire logic [31:0] lb_rdata,
   // system bus
   output logic sb_req,
   input wire logic sb_ack,
   input wire logic sb_err,
   input wire logic [31:0] sb_rdata,
   // interrupts
   output logic irq,
   output logic nmi
);
   localparam int CHW = $clog2(NCH);
   localparam int AW = $clog2(DEPTH);
   localparam int NP = NCH / 2;

   // pairs need an even count; decode reaches eight channels at most
   if (NCH < 4 || NCH > 8 || NCH % 2 != 0 || DEPTH < 2 ||
       (1 << AW) != DEPTH) begin : g_bad
      $error("dma: unsupported NCH or DEPTH");
   end

   // ***************************************************
   // state
   // ***************************************************
   typedef struct packed {
      logic [NCH-1:0][`CFG_W-1:0] cfg;
      logic [NCH-1:0][31:0] addr;
      logic [NCH-1:0][31:0] nxa;
      logic [NCH-1:0][15:0] size;
      logic [NCH-1:0][15:0] nxs;
      logic [NCH-1:0] done;
      logic [NCH-1:0] mask;
      logic [1:0] berr;
      logic [31:0] sea;
      logic [31:0] lea;
      logic [3:0] ser;
      logic [3:0] ler;
      logic irq;
      logic nmi;
      logic [NP-1:0][DEPTH-1:0][31:0] mem;
      logic [NP-1:0][AW:0] wp;
      logic [NP-1:0][AW:0] rp;
      logic [NP-1:0] drain;
      dma_pkg::eng_t eng;
      logic [CHW-1:0] ch;
      logic bus;
      logic [1:0] breq;
      logic we;
      logic fly;
      logic [31:0] ba;
      logic [31:0] bwd;
      logic awrdy;
      logic bvld;
      logic [1:0] bresp;
      logic arrdy;
      logic rvld;
      logic [1:0] rresp;
      logic [31:0] rdat;
   } st_t;

   st_t q;
   st_t d;
   logic ack;
   logic err;
   logic fin;
   logic iss;
   logic [7:0] rqv;

   // address decode shared by read and write paths
   function automatic dma_pkg::dec_t dec(input logic [11:0] a);
      dma_pkg::dec_t r;
      r.glb = (a[11:8] == `GLB_PAGE);
      r.ch = a[7:5];
      r.fld = r.glb ? a[5:2] : {1'b0, a[4:2]};
      r.ok = r.glb ? (a[7:6] == 2'h0 && r.fld <= `G_FIFO) :
             (a[11:8] == 4'h0 && 32'(r.ch) < NCH &&
              r.fld <= {1'b0, `F_LAST});
      return r;
   endfunction

   // byte-lane merge for partial writes
   function automatic logic [31:0] mrg(input logic [31:0] o,
                                       input logic [31:0] n,
                                       input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[b*8 +: 8] = n[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // request lines by requestor number; codes 6 and 7 never fire
   assign rqv = {2'h0, ext_req, filter_coprocessor_req,
                 host_port_req}; // [RL15]
   assign ack = q.bus ? sb_ack : lb_ack;
   assign err = q.bus ? sb_err : lb_err;
   assign fin = (q.eng == dma_pkg::ENG_ACCESS) && ack;

   // ***************************************************
   // next state
   // ***************************************************
   always_comb begin
      dma_pkg::dec_t wdc;
      dma_pkg::dec_t rdc;
      logic [31:0] rin;
      logic [31:0] rv;
      logic [CHW-2:0] p;
      logic [AW:0] cnt;
      logic [`CFG_W-1:0] cf;
      logic el;
      logic fnd;
      logic [CHW-1:0] pc;
      d = q;
      wdc = dec(s_awaddr);
      rdc = dec(s_araddr);
      rin = q.bus ? sb_rdata : lb_rdata;
      p = q.ch[CHW-1:1];
      rv = 32'h0;
      fnd = 1'b0;
      pc = '0;
      cnt = '0;
      cf = '0;
      el = 1'b0;
      iss = 1'b0;
      d.awrdy = 1'b0;
      d.arrdy = 1'b0;
      // write channel: ready pulses once both address and data wait
      if (q.awrdy) begin
         d.bvld = 1'b1;
         d.bresp = wdc.ok ? `RESP_OK : `RESP_SLVERR;
         if (wdc.ok && !wdc.glb) begin
            case (wdc.fld[2:0])
               `F_CFG: d.cfg[wdc.ch] = `CFG_W'(mrg(32'(q.cfg[wdc.ch]),
                                          s_wdata, s_wstrb));
               `F_ADDR: d.addr[wdc.ch] = mrg(q.addr[wdc.ch], s_wdata,
                                            s_wstrb);
               `F_SIZE: d.size[wdc.ch] = 16'(mrg(32'(q.size[wdc.ch]),
                                          s_wdata, s_wstrb));
               `F_NADDR: d.nxa[wdc.ch] = mrg(q.nxa[wdc.ch], s_wdata,
                                            s_wstrb);
               default: d.nxs[wdc.ch] = 16'(mrg(32'(q.nxs[wdc.ch]),
                                          s_wdata, s_wstrb));
            endcase
         end else if (wdc.ok) begin
            case (wdc.fld)
               `G_DONE: d.done = q.done & ~NCH'(s_wdata);
               `G_MASK: d.mask = NCH'(s_wdata);
               `G_BERR: d.berr = q.berr & ~s_wdata[1:0];
               default: ;
            endcase
         end
      end else if (!q.bvld && s_awvalid && s_wvalid) begin
         d.awrdy = 1'b1;
      end
      if (q.bvld && s_bready) begin
         d.bvld = 1'b0;
      end
      // read channel
      if (rdc.ok && !rdc.glb) begin
         case (rdc.fld[2:0])
            `F_CFG: rv = 32'(q.cfg[rdc.ch]);
            `F_ADDR: rv = q.addr[rdc.ch];
            `F_SIZE: rv = 32'(q.size[rdc.ch]);
            `F_NADDR: rv = q.nxa[rdc.ch];
            default: rv = 32'(q.nxs[rdc.ch]);
         endcase
      end else if (rdc.ok) begin
         case (rdc.fld)
            `G_DONE: rv = 32'(q.done);
            `G_MASK: rv = 32'(q.mask);
            `G_BERR: rv = 32'(q.berr);
            `G_SEA: rv = q.sea;
            `G_SER: rv = 32'(q.ser);
            `G_LEA: rv = q.lea;
            `G_LER: rv = 32'(q.ler);
            default: rv = 32'(q.drain);
         endcase
      end
      if (q.arrdy) begin
         d.rvld = 1'b1;
         d.rdat = rv;
         d.rresp = rdc.ok ? `RESP_OK : `RESP_SLVERR;
      end else if (!q.rvld && s_arvalid) begin
         d.arrdy = 1'b1;
      end
      if (q.rvld && s_rready) begin
         d.rvld = 1'b0;
      end
      // engine completion runs after software so hardware sets win
      if (fin) begin
         d.breq = 2'h0; // [RL2]
         d.eng = dma_pkg::ENG_IDLE;
         if (err) begin
            // faulting channel stops; software restarts it
            d.cfg[q.ch][`CB_ACTIVE] = 1'b0;
            if (q.bus) begin
               d.berr[`BERR_SYS] = 1'b1; // [RL7]
               d.sea = q.ba;
               d.ser = 4'(q.ch);
            end else begin
               d.berr[`BERR_LOC] = 1'b1; // [RL8]
               d.lea = q.ba;
               d.ler = 4'(q.ch);
            end
         end else begin
            if (!q.fly && !q.ch[0]) begin
               d.mem[p][q.wp[p][AW-1:0]] = rin; // [RL10] [RL16]
               d.wp[p] = q.wp[p] + 1'b1;
            end
            if (!q.fly && q.ch[0]) begin
               d.rp[p] = q.rp[p] + 1'b1; // [RL16]
            end
            d.addr[q.ch] = q.addr[q.ch] + `ADDR_STEP;
            d.size[q.ch] = q.size[q.ch] - 16'h1;
            if (q.size[q.ch] == 16'h1) begin
               d.done[q.ch] = 1'b1;
               if (!q.fly && !q.ch[0] && q.cfg[q.ch][`CB_FLUSH]) begin
                  d.drain[p] = 1'b1; // [RL4]
               end
               if (q.cfg[q.ch][`CB_CHAIN]) begin
                  d.addr[q.ch] = q.nxa[q.ch]; // [RL3]
                  d.size[q.ch] = q.nxs[q.ch];
               end else begin
                  d.cfg[q.ch][`CB_ACTIVE] = 1'b0;
               end
            end
         end
      end
      // flush ends when the pair fifo is empty
      for (int i = 0; i < NP; i++) begin
         if (d.wp[i] == d.rp[i]) begin
            d.drain[i] = 1'b0;
         end
      end
      // pick lowest ready channel; may follow a finish at once
      if (d.eng == dma_pkg::ENG_IDLE) begin
         for (int c = NCH - 1; c >= 0; c--) begin
            cf = d.cfg[c];
            cnt = d.wp[c/2] - d.rp[c/2];
            // flyby only starts on an external request
            el = cf[`CB_ACTIVE] && d.size[c] != 16'h0 &&
                 (cf[`CB_INT] ? !cf[`CB_FLY] :
                  rqv[cf[`CB_RQ_HI:`CB_RQ_LO]]); // [RL15]
            if (!cf[`CB_FLY]) begin
               el = el && (c[0] ? cnt != '0 :
                    (cnt != (AW+1)'(DEPTH) && !d.drain[c/2]));
            end
            if (el) begin
               fnd = 1'b1;
               pc = CHW'(c);
            end
         end
         if (fnd) begin
            iss = 1'b1; // [RL9]
            d.eng = dma_pkg::ENG_ACCESS;
            d.ch = pc;
            d.bus = d.cfg[pc][`CB_BUS];
            d.breq = d.cfg[pc][`CB_BUS] ? 2'h2 : 2'h1; // [RL1]
            d.we = pc[0]; // [RL11]
            d.fly = d.cfg[pc][`CB_FLY]; // [RL12]
            d.ba = d.addr[pc];
            d.bwd = (!d.cfg[pc][`CB_FLY] && pc[0]) ?
                    d.mem[pc[CHW-1:1]][d.rp[pc[CHW-1:1]][AW-1:0]] :
                    32'h0;
         end
      end
      d.irq = |(d.done & d.mask);
      d.nmi = |d.berr; // [RL6]
   end

   // ***************************************************
   // registers
   // ***************************************************
   // single register stage for the whole block
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // outputs straight from the state flops
   assign s_awready = q.awrdy;
   assign s_wready = q.awrdy;
   assign s_bvalid = q.bvld;
   assign s_bresp = q.bresp;
   assign s_arready = q.arrdy;
   assign s_rvalid = q.rvld;
   assign s_rresp = q.rresp;
   assign s_rdata = q.rdat;
   assign lb_req = q.breq[0];
   assign sb_req = q.breq[1];
   assign acc_we = q.we;
   assign acc_fly = q.fly;
   assign acc_addr = q.ba;
   assign acc_wdata = q.bwd;
   assign irq = q.irq;
   assign nmi = q.nmi;

   // ***************************************************
   // checks
   // ***************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   a_bus_route: assert property (iss |=> (sb_req == q.cfg[q.ch][`CB_BUS]
      && lb_req == !q.cfg[q.ch][`CB_BUS])) // [RL1]
      else $error("access on wrong bus");
   a_bus_hold: assert property ((lb_req || sb_req) && !ack |=>
      $stable(q.breq) && $stable(acc_addr) && !(lb_req && sb_req)) // [RL2]
      else $error("bus request dropped before ack");
   a_chain_load: assert property (fin && !err && q.size[q.ch] == 16'h1
      && q.cfg[q.ch][`CB_CHAIN] |-> d.addr[q.ch] == q.nxa[q.ch]) // [RL3]
      else $error("chain did not reload address");
   a_flush_hold: assert property (iss && !d.fly && !d.ch[0] |->
      !d.drain[d.ch[CHW-1:1]]) // [RL4]
      else $error("read issued during flush");
   a_err_nmi: assert property (fin && err |=> nmi ##1 nmi) // [RL6]
      else $error("bus error without nmi");
   a_sys_capture: assert property (fin && q.bus && err |=>
      q.berr[`BERR_SYS] && q.sea == $past(q.ba)) // [RL7]
      else $error("system error not captured");
   a_loc_capture: assert property (fin && !q.bus && err |=>
      q.berr[`BERR_LOC] && q.lea == $past(q.ba)) // [RL8]
      else $error("local error not captured");
   a_back_back: assert property (fin && iss |=> lb_req || sb_req) // [RL9]
      else $error("idle cycle between channels");
   a_pair_dir: assert property ((lb_req || sb_req) |->
      acc_we == q.ch[0]) // [RL11]
      else $error("pair direction wrong");
   a_fly_nofifo: assert property (fin && q.fly |=>
      $stable(q.wp) && $stable(q.rp)) // [RL12]
      else $error("flyby touched fifo");
   a_fifo_order: assert property (fin && !err && !q.fly && q.ch[0] |->
      q.bwd == q.mem[q.ch[CHW-1:1]][q.rp[q.ch[CHW-1:1]][AW-1:0]]) // [RL16]
      else $error("fifo order broken");
   a_ext_trig: assert property (iss && !d.cfg[d.ch][`CB_INT] |->
      rqv[d.cfg[d.ch][`CB_RQ_HI:`CB_RQ_LO]]) // [RL15]
      else $error("start without request");
endmodule
`default_nettype wire

// *** sim/bus_model.sv ***
// memory on one bus, answering the dma access port
// assumes req and access fields hold until the edge that samples ack
`default_nettype none
module bus_model (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // access from the dma
   input wire logic req,
   input wire logic we,
   input wire logic fly,
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata,
   // byte address that answers with an error
   input wire logic [31:0] bad,
   // answer
   output logic ack,
   output logic err,
   output logic [31:0] rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] mem [256];
   logic [1:0] wait_q;
   int n_fly;
   // *********************************
   // memory and answer
   // *********************************
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = {16'hBEEF, 16'(i)};
   end
   // wait varies with the last address: prompt and slow answers
   // plain always: the array is also filled by the initial block above
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ack <= 1'b0;
         err <= 1'b0;
         wait_q <= 2'h0;
         n_fly <= 0;
         rdata <= 32'h0;
      end else if (ack) begin
         ack <= 1'b0;
         err <= 1'b0;
         rdata <= ~rdata;
      end else if (req && wait_q != 2'h0) begin
         wait_q <= wait_q - 2'h1;
         rdata <= ~rdata;
      end else if (req) begin
         ack <= 1'b1;
         err <= (addr == bad);
         rdata <= mem[addr[9:2]];
         if (we) mem[addr[9:2]] <= wdata;
         if (fly) n_fly <= n_fly + 1;
         wait_q <= addr[3:2];
      end else begin
         rdata <= ~rdata; // released data never keeps its value
      end
   end
endmodule
`default_nettype wire

// *** sim/test_dual_bus_dma_controller.sv ***
// self-checking bench of the dual bus dma controller
// assumes one bus_model per bus, registers reached over axi4-lite
`default_nettype none
module test_dual_bus_dma_controller;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys, rst_b, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq, nmi;
   logic [11:0] s_awaddr, s_araddr;
   logic [31:0] s_wdata, s_rdata, acc_addr, acc_wdata, lb_rdata, sb_rdata, d;
   logic [31:0] lb_bad, sb_bad;
   logic [3:0] s_wstrb, ext_req;
   logic [1:0] s_bresp, s_rresp, rsp;
   logic host_port_req, filter_coprocessor_req, acc_we, acc_fly;
   logic lb_req, lb_ack, lb_err, sb_req, sb_ack, sb_err, sb, db;
   int seed, fails, n_compared, n, f;
   // *********************************
   // design and bus partners
   // *********************************
   dual_bus_dma_controller #(.NCH(8), .DEPTH(4)) DUT (.clk_sys, .rst_b,
      .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
      .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
      .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .host_port_req,
      .filter_coprocessor_req, .ext_req, .acc_we, .acc_fly, .acc_addr,
      .acc_wdata, .lb_req, .lb_ack, .lb_err, .lb_rdata, .sb_req, .sb_ack,
      .sb_err, .sb_rdata, .irq, .nmi);
   bus_model lbm (.clk_sys, .rst_b, .req(lb_req), .we(acc_we), .fly(acc_fly),
      .addr(acc_addr), .wdata(acc_wdata), .bad(lb_bad), .ack(lb_ack),
      .err(lb_err), .rdata(lb_rdata));
   bus_model sbm (.clk_sys, .rst_b, .req(sb_req), .we(acc_we), .fly(acc_fly),
      .addr(acc_addr), .wdata(acc_wdata), .bad(sb_bad), .ack(sb_ack),
      .err(sb_err), .rdata(sb_rdata));
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // *********************************
   // helpers
   // *********************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string m);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: %s %h not %h", $time, m, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // write address and data offered together, bready up from the start
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      s_awaddr <= a;
      s_wdata <= v;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      do @(posedge clk_sys); while (s_awready !== 1'b1);
      s_awvalid <= 1'b0;
      s_wvalid <= 1'b0;
      do @(posedge clk_sys); while (s_bvalid !== 1'b1);
      rsp = s_bresp; // bready stays up so back-to-back calls never toggle it
   endtask
   task automatic rd(input logic [11:0] a);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      do @(posedge clk_sys); while (s_arready !== 1'b1);
      s_arvalid <= 1'b0;
      do @(posedge clk_sys); while (s_rvalid !== 1'b1);
      d = s_rdata;
      rsp = s_rresp; // rready stays up so back-to-back calls never toggle it
   endtask
   function automatic logic [31:0] cfgv(input logic bs, input logic fy,
      input logic in, input logic fl, input logic ch, input logic [2:0] rq);
      return {21'h0, rq, 2'h0, ch, fl, in, fy, bs, 1'b1};
   endfunction
   function automatic logic [31:0] pat(input int i);
      return {16'hBEEF, 16'(i)};
   endfunction
   function automatic logic [31:0] word(input logic b, input int i);
      return b ? sbm.mem[i] : lbm.mem[i];
   endfunction
   // config word last, so the channel starts fully programmed
   task automatic setch(input int c, input logic [31:0] cf,
      input logic [31:0] a, input logic [31:0] sz, input logic [31:0] na,
      input logic [31:0] ns);
      wr(12'(c * 32 + 4), a);
      wr(12'(c * 32 + 8), sz);
      wr(12'(c * 32 + 12), na);
      wr(12'(c * 32 + 16), ns);
      wr(12'(c * 32), cf);
   endtask
   task automatic wait_done(input logic [31:0] m);
      int k;
      k = 0;
      rd(12'h100);
      while ((d & m) !== m && k < 200) begin
         rd(12'h100);
         k++;
      end
      chk(d & m, m, "done bits");
   endtask
   task automatic wait_nmi();
      int k;
      k = 0;
      while (nmi !== 1'b1 && k < 200) begin
         @(posedge clk_sys);
         k++;
      end
      chk({31'h0, nmi}, 32'h1, "nmi");
   endtask
   // *********************************
   // tests
   // *********************************
   initial begin
      seed = 67;
      {rst_b, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 6'h0;
      {host_port_req, filter_coprocessor_req, ext_req} = 6'h0;
      {s_awaddr, s_araddr, s_wdata} = 56'h0;
      s_wstrb = 4'hF;
      lb_bad = 32'hFFFFFFFF;
      sb_bad = 32'hFFFFFFFF;
      repeat (20) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      rd(12'h108);
      chk(d, 32'h0, "error status at reset");
      rd(12'hFFC);
      chk({d[29:0], rsp}, 32'h2, "unmapped read");
      wr(12'hFFC, 32'hFFFFFFFF);
      chk({30'h0, rsp}, 32'h2, "unmapped write");
      $display("test registers finished");
      // dual access on every pair, buses and lengths drawn at random
      for (int p = 0; p < 4; p++) begin
         sb = 1'($random(seed));
         db = 1'($random(seed));
         n = 1 + $unsigned($random(seed)) % 6;
         setch(2 * p + 1, cfgv(db, 0, 1, 0, 0, 0), 32'h200 + 64 * p, n, 0, 0);
         setch(2 * p, cfgv(sb, 0, 1, 0, 0, 0), 64 * p, n, 0, 0);
         wait_done(32'h3 << (2 * p));
         for (int k = 0; k < n; k++)
            chk(word(db, 128 + 16 * p + k), pat(16 * p + k), "copy");
      end
      chk({31'h0, irq}, 32'h0, "irq while masked");
      wr(12'h104, 32'h1);
      repeat (2) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h1, "irq unmasked");
      wr(12'h100, 32'hFF);
      repeat (2) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0, "irq after clear");
      wr(12'h104, 32'h0);
      $display("test dual access finished");
      // every requestor drives one flyby access, even and odd channel
      for (int k = 0; k < 6; k++) begin
         f = sbm.n_fly;
         {ext_req, filter_coprocessor_req, host_port_req} <= 6'h1 << k;
         setch(4 + k % 2, cfgv(1, 1, 0, 0, 0, 3'(k)), 32'h100, 1, 0, 0);
         wait_done(32'h1 << (4 + k % 2));
         chk(32'(sbm.n_fly - f), 32'h1, "flyby count");
         {ext_req, filter_coprocessor_req, host_port_req} <= 6'h0;
         wr(12'h100, 32'hFF);
      end
      setch(6, cfgv(1, 1, 1, 0, 0, 3'h2), 32'h100, 1, 0, 0);
      ext_req <= 4'h1;
      repeat (30) @(posedge clk_sys);
      rd(12'h100);
      chk(d & 32'h40, 32'h0, "flyby with internal request");
      ext_req <= 4'h0;
      wr(12'h0C0, 32'h0);
      $display("test flyby finished");
      // chained buffers with flush, crossing to the system bus
      setch(3, cfgv(1, 0, 1, 0, 0, 0), 32'h300, 5, 0, 0);
      setch(2, cfgv(0, 0, 1, 1, 1, 0), 32'h080, 2, 32'h0C0, 3);
      wait_done(32'h8);
      wr(12'h040, 32'h0);
      for (int k = 0; k < 5; k++)
         chk(word(1, 192 + k), pat(k < 2 ? 32 + k : 46 + k), "chain");
      $display("test chain finished");
      // bus errors on either bus
      lb_bad <= 32'h010;
      setch(1, cfgv(1, 0, 1, 0, 0, 0), 32'h380, 1, 0, 0);
      setch(0, cfgv(0, 0, 1, 0, 0, 0), 32'h010, 1, 0, 0);
      wait_nmi();
      rd(12'h108);
      chk(d, 32'h2, "local error flag");
      rd(12'h114);
      chk(d, 32'h010, "local error address");
      rd(12'h118);
      chk(d, 32'h0, "local error channel");
      wr(12'h020, 32'h0);
      wr(12'h108, 32'h2);
      repeat (2) @(posedge clk_sys);
      chk({31'h0, nmi}, 32'h0, "nmi after clear");
      sb_bad <= 32'h020;
      setch(4, cfgv(1, 0, 1, 0, 0, 0), 32'h020, 1, 0, 0);
      wait_nmi();
      rd(12'h108);
      chk(d, 32'h1, "system error flag");
      rd(12'h10C);
      chk(d, 32'h020, "system error address");
      rd(12'h110);
      chk(d, 32'h4, "system error channel");
      $display("test bus errors finished");
      give_verdict();
   end
   // hang guard, far beyond the several hundred cycles the tests take
   initial begin
      #(100 * 60000);
      fails++;
      $display("unexpected at %0t: watchdog expired", $time);
      give_verdict();
   end
endmodule
`default_nettype wire
